// *** core/cps_consts.vh ***
// Purpose: Shared constants of the charge pulse sequencer.
// Assumes: Times are given in microseconds; the clock rate in MHz.
// Notes: Cycle counts are derived in the module from these figures.
`ifndef CPS_CONSTS_VH
`define CPS_CONSTS_VH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define CPS_CLK_MHZ 200

// ----------------------------------------------------------------
// Times in microseconds
// ----------------------------------------------------------------
`define CPS_T_RESET_US 700000
`define CPS_T_CHG_US 1048000
`define CPS_T_DIS_US 5000
`define CPS_T_REST_US 4000
`define CPS_T_ACQ_US 16400
`define CPS_T_CYCLE_US 1077000
`define CPS_T_CAP_PULSE_US 5000
`define CPS_T_CAP_PERIOD_US 100000
`define CPS_T_DET_PULSE_US 100000
`define CPS_T_DET_PERIOD_US 624000
`define CPS_T_SOFT_INIT_US 200000
`define CPS_T_SOFT_INC_US 7000
`define CPS_T_RATE_WIN_US 1160000

// ----------------------------------------------------------------
// Fast-charge timer and reset values
// ----------------------------------------------------------------
`define CPS_FAST_CYCLES_4C 1000
`define CPS_RATE_RST 2'h0

`endif

// *** core/cps_sequencer.v ***
// Purpose: Charge pulse sequencer: polling, soft start, fast charge, timing.
// Assumes: All inputs are synchronous to sys_clk; comparators are external.
// Notes: Drive outputs lag the sequencer state by one clock.
`include "cps_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module cps_sequencer #(
	parameter integer RST_CYC = `CPS_T_RESET_US * `CPS_CLK_MHZ,
	parameter integer CHG_CYC = `CPS_T_CHG_US * `CPS_CLK_MHZ,
	parameter integer DIS_CYC = `CPS_T_DIS_US * `CPS_CLK_MHZ,
	parameter integer REST_CYC = `CPS_T_REST_US * `CPS_CLK_MHZ,
	parameter integer ACQ_CYC = `CPS_T_ACQ_US * `CPS_CLK_MHZ,
	parameter integer CAP_CYC = `CPS_T_CAP_PULSE_US * `CPS_CLK_MHZ,
	parameter integer CAP_PER_CYC = `CPS_T_CAP_PERIOD_US * `CPS_CLK_MHZ,
	parameter integer DET_CYC = `CPS_T_DET_PULSE_US * `CPS_CLK_MHZ,
	parameter integer DET_PER_CYC = `CPS_T_DET_PERIOD_US * `CPS_CLK_MHZ,
	parameter integer SOFT_INIT_CYC = `CPS_T_SOFT_INIT_US * `CPS_CLK_MHZ,
	parameter integer SOFT_INC_CYC = `CPS_T_SOFT_INC_US * `CPS_CLK_MHZ,
	parameter integer WIN_CYC = `CPS_T_RATE_WIN_US * `CPS_CLK_MHZ,
	parameter integer FAST_CYCLES_4C = `CPS_FAST_CYCLES_4C,
	parameter integer TW = 28
) (
	// Clock and reset
	input wire sys_clk,
	input wire sys_rst,
	input wire master_reset_low,
	// Sensing inputs from the analog front end
	input wire temperature_input,
	input wire battery_detect,
	input wire voltage_full,
	input wire [1:0] rate_select,
	// Drives to the current source and discharge circuit
	output reg charge_drive,
	output reg discharge_drive,
	// Status
	output wire polling_active,
	output wire soft_start_active,
	output wire fast_charge_active,
	output wire charge_done,
	output wire hot_fault,
	output wire rate_window_open,
	output wire [1:0] rate_active
);

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam [2:0] ST_POLL = 3'h0;
	localparam [2:0] ST_CHG = 3'h1;
	localparam [2:0] ST_DIS = 3'h2;
	localparam [2:0] ST_REST = 3'h3;
	localparam [2:0] ST_ACQ = 3'h4;
	localparam [2:0] ST_DONE = 3'h5;
	localparam [2:0] ST_FAULT = 3'h6;

	reg [TW-1:0] rst_cnt_reg;
	reg held_reg;
	reg [TW-1:0] win_cnt_reg;
	reg win_open_reg;
	reg [1:0] rate_reg;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg soft_reg;
	reg [TW-1:0] tmr_reg;
	reg [TW-1:0] cap_tmr_reg;
	reg [TW-1:0] chg_len_reg;
	reg [15:0] fast_cnt_reg;
	reg charge_next;
	reg discharge_next;
	wire [15:0] fast_limit;
	wire in_cycle;
	wire tmr_end;

	// ----------------------------------------------------------------
	// Reset input debounce
	// ----------------------------------------------------------------
	// A short glitch on the reset pin restarts nothing; only a long hold does.
	always @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rst_cnt_reg <= {TW{1'b0}};
			held_reg <= 1'b0;
		end
		else if (master_reset_low)
		begin
			rst_cnt_reg <= {TW{1'b0}};
			held_reg <= 1'b0;
		end
		else if (rst_cnt_reg == RST_CYC[TW-1:0] - 1'b1)
			held_reg <= 1'b1;
		else
			rst_cnt_reg <= rst_cnt_reg + 1'b1;
	end

	// ----------------------------------------------------------------
	// Rate-select window
	// ----------------------------------------------------------------
	always @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			win_cnt_reg <= {TW{1'b0}};
			win_open_reg <= 1'b1;
			rate_reg <= `CPS_RATE_RST;
		end
		else if (held_reg)
		begin
			win_cnt_reg <= {TW{1'b0}};
			win_open_reg <= 1'b1;
		end
		else if (win_open_reg)
		begin
			rate_reg <= rate_select;
			win_cnt_reg <= win_cnt_reg + 1'b1;
			if (win_cnt_reg == WIN_CYC[TW-1:0] - 1'b1)
				win_open_reg <= 1'b0;
		end
	end

	assign rate_window_open = win_open_reg;
	assign rate_active = rate_reg;
	// Rate 0 is the fastest rate; each slower rate doubles the allowed time.
	assign fast_limit = FAST_CYCLES_4C[15:0] << rate_reg;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	assign in_cycle = (state_reg == ST_CHG) || (state_reg == ST_DIS) ||
		(state_reg == ST_REST) || (state_reg == ST_ACQ);
	assign tmr_end = ((state_reg == ST_CHG) && (tmr_reg == chg_len_reg - 1'b1)) ||
		((state_reg == ST_DIS) && (tmr_reg == DIS_CYC[TW-1:0] - 1'b1)) ||
		((state_reg == ST_REST) && (tmr_reg == REST_CYC[TW-1:0] - 1'b1)) ||
		((state_reg == ST_ACQ) && (tmr_reg == ACQ_CYC[TW-1:0] - 1'b1)) ||
		((state_reg == ST_POLL) && (tmr_reg == DET_PER_CYC[TW-1:0] - 1'b1));

	always @*
	begin
		state_next = state_reg;
		if (temperature_input)
			state_next = ST_FAULT;
		else
		begin
			case (state_reg)
				ST_POLL:
					if (tmr_reg == DET_CYC[TW-1:0] - 1'b1 && battery_detect)
						state_next = ST_CHG;
				ST_CHG:
					if (tmr_end)
						state_next = ST_DIS;
				ST_DIS:
					if (tmr_end)
						state_next = ST_REST;
				ST_REST:
					if (tmr_end)
						state_next = ST_ACQ;
				ST_ACQ:
					if (tmr_end)
					begin
						if (!soft_reg && (voltage_full || fast_cnt_reg == fast_limit - 1'b1))
							state_next = ST_DONE;
						else
							state_next = ST_CHG;
					end
				ST_DONE:
					state_next = ST_DONE;
				default:
					state_next = ST_FAULT;
			endcase
		end
	end

	always @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_reg <= ST_POLL;
			soft_reg <= 1'b1;
			tmr_reg <= {TW{1'b0}};
			cap_tmr_reg <= {TW{1'b0}};
			chg_len_reg <= SOFT_INIT_CYC[TW-1:0];
			fast_cnt_reg <= 16'h0000;
		end
		else if (held_reg)
		begin
			state_reg <= ST_POLL;
			soft_reg <= 1'b1;
			tmr_reg <= {TW{1'b0}};
			cap_tmr_reg <= {TW{1'b0}};
			chg_len_reg <= SOFT_INIT_CYC[TW-1:0];
			fast_cnt_reg <= 16'h0000;
		end
		else
		begin
			state_reg <= state_next;
			if (state_next != state_reg || tmr_end)
				tmr_reg <= {TW{1'b0}};
			else
				tmr_reg <= tmr_reg + 1'b1;
			if (cap_tmr_reg == CAP_PER_CYC[TW-1:0] - 1'b1)
				cap_tmr_reg <= {TW{1'b0}};
			else
				cap_tmr_reg <= cap_tmr_reg + 1'b1;
			if (state_reg == ST_ACQ && state_next == ST_CHG)
			begin
				// Soft start hands over to fast charge once one more step would make its pulse reach or pass full width.
				if (soft_reg && chg_len_reg + SOFT_INC_CYC[TW-1:0] < CHG_CYC[TW-1:0])
					chg_len_reg <= chg_len_reg + SOFT_INC_CYC[TW-1:0];
				else
				begin
					soft_reg <= 1'b0;
					chg_len_reg <= CHG_CYC[TW-1:0];
				end
				if (!soft_reg)
					fast_cnt_reg <= fast_cnt_reg + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Drive outputs
	// ----------------------------------------------------------------
	always @*
	begin
		charge_next = 1'b0;
		discharge_next = 1'b0;
		if (held_reg)
		begin
			charge_next = 1'b0;
			discharge_next = 1'b0;
		end
		else if (state_reg == ST_POLL)
		begin
			charge_next = (tmr_reg < DET_CYC[TW-1:0]);
			// A capacitor pulse is only started where it fits whole between two detection
			// pulses, so a pulse that would collide is skipped rather than cut short.
			discharge_next = (cap_tmr_reg < CAP_CYC[TW-1:0]) &&
				(tmr_reg >= DET_CYC[TW-1:0] + cap_tmr_reg) &&
				(tmr_reg - cap_tmr_reg <= DET_PER_CYC[TW-1:0] - CAP_CYC[TW-1:0]);
		end
		else if (in_cycle)
		begin
			charge_next = (state_reg == ST_CHG);
			discharge_next = (state_reg == ST_DIS);
		end
	end

	always @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			charge_drive <= 1'b0;
			discharge_drive <= 1'b0;
		end
		else
		begin
			charge_drive <= charge_next && !temperature_input;
			discharge_drive <= discharge_next;
		end
	end

	assign polling_active = (state_reg == ST_POLL);
	assign soft_start_active = in_cycle && soft_reg;
	assign fast_charge_active = in_cycle && !soft_reg;
	assign charge_done = (state_reg == ST_DONE);
	assign hot_fault = (state_reg == ST_FAULT);

endmodule // cps_sequencer

`default_nettype wire

// *** bench/cps_sequencer_monitor.sv ***
// Purpose: Port assertions for the sequencer.
// Assumes: Drives lag the state by one clock.
// Notes: Bound to every cps_sequencer.
`timescale 1ns/1ps
`default_nettype none
module cps_sequencer_monitor #(
	parameter integer DET_CYC = 10,
	parameter integer DIS_CYC = 5,
	parameter integer CAP_CYC = 5
) (
	// Clock, resets and temperature input
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic master_reset_low,
	input wire logic temperature_input,
	// Outputs watched
	input wire logic charge_drive,
	input wire logic discharge_drive,
	input wire logic polling_active,
	input wire logic soft_start_active,
	input wire logic fast_charge_active,
	input wire logic charge_done,
	input wire logic hot_fault,
	input wire logic rate_window_open,
	input wire logic [1:0] rate_active
);
	int ccnt;
	int dcnt;
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ccnt <= 0;
			dcnt <= 0;
		end
		else
		begin
			ccnt <= charge_drive ? ccnt + 1 : 0;
			dcnt <= discharge_drive ? dcnt + 1 : 0;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence quiet8;
		(!charge_drive && !discharge_drive) [*8];
	endsequence
	dis_len_a: assert property ($fell(discharge_drive) && !hot_fault && master_reset_low
		|-> dcnt == (polling_active ? CAP_CYC : DIS_CYC)) else $error("discharge pulse length");
	det_len_a: assert property ($fell(charge_drive) && polling_active && master_reset_low
		|-> ccnt == DET_CYC) else $error("detect pulse length");
	no_overlap_a: assert property (!(charge_drive && discharge_drive)) else $error("overlap");
	dis_follow_a: assert property ($fell(charge_drive) && (soft_start_active ||
		fast_charge_active) |-> discharge_drive) else $error("no discharge");
	rest_quiet_a: assert property ($fell(discharge_drive) && (soft_start_active ||
		fast_charge_active) |-> quiet8) else $error("rest not quiet");
	hot_stop_a: assert property (temperature_input && master_reset_low
		|=> hot_fault ##1 quiet8) else $error("hot not stopped");
	fault_keep_a: assert property (hot_fault && master_reset_low |=> hot_fault)
		else $error("fault lost");
	done_keep_a: assert property (charge_done && master_reset_low && !temperature_input
		|=> charge_done && !charge_drive) else $error("done lost");
	win_freeze_a: assert property (!rate_window_open && master_reset_low
		|=> $stable(rate_active) && !rate_window_open) else $error("rate moved");
endmodule // cps_sequencer_monitor
bind cps_sequencer cps_sequencer_monitor #(.DET_CYC(DET_CYC), .DIS_CYC(DIS_CYC),
	.CAP_CYC(CAP_CYC)) u_cps_sequencer_monitor (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.master_reset_low(master_reset_low), .temperature_input(temperature_input),
	.charge_drive(charge_drive), .discharge_drive(discharge_drive),
	.polling_active(polling_active), .soft_start_active(soft_start_active),
	.fast_charge_active(fast_charge_active), .charge_done(charge_done),
	.hot_fault(hot_fault), .rate_window_open(rate_window_open), .rate_active(rate_active));
`default_nettype wire

// *** bench/cps_battery_model.sv ***
// Purpose: Battery and current source at the drive pins.
// Assumes: A battery is detected only while current flows; voltage_full needs no current.
// Notes: Full charge is a plain flag.
`timescale 1ns/1ps
`default_nettype none
module cps_battery_model (
	// Drive in
	input wire logic charge_drive,
	// Bench controls
	input wire logic present,
	input wire logic full,
	// Sense out
	output logic battery_detect,
	output logic voltage_full
);
	// Without current the terminals read empty, so detection needs a pulse.
	assign battery_detect = present & charge_drive;
	assign voltage_full = present & full;
endmodule // cps_battery_model
`default_nettype wire

// *** bench/cps_sequencer_tb_top.sv ***
// Purpose: Self-checking bench for the sequencer.
// Assumes: Shortened counts.
// Notes: Pulse lengths measured at the drives.
`timescale 1ns/1ps
`default_nettype none
module cps_sequencer_tb_top;
	localparam int RST = 20, CHARGE_DRIVE = 60, SI = 20, SINC = 7, DET = 10, DPER = 62, FAST = 3;
	localparam int CAP = 5, CAPP = 25;
	logic sys_clk, sys_rst, master_reset_low, temperature_input;
	logic present, full, dprev;
	logic [1:0] rate_select, r;
	wire logic charge_drive, discharge_drive, battery_detect, voltage_full, polling_active;
	wire logic soft_start_active, fast_charge_active, charge_done, hot_fault, rate_window_open;
	wire logic [1:0] rate_active;
	int n_errors = 0, n_checks = 0, run = 0, nsoft = 0, nfast = 0, rise = 0, cyc = 0;
	int drise = 0;
	cps_sequencer #(.RST_CYC(RST), .CHG_CYC(CHARGE_DRIVE), .SOFT_INIT_CYC(SI), .SOFT_INC_CYC(SINC),
		.DIS_CYC(5), .REST_CYC(4), .ACQ_CYC(8), .DET_CYC(DET), .DET_PER_CYC(DPER),
		.CAP_CYC(CAP), .CAP_PER_CYC(CAPP), .WIN_CYC(116), .FAST_CYCLES_4C(FAST)) u_cps_sequencer (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .master_reset_low(master_reset_low),
		.temperature_input(temperature_input), .battery_detect(battery_detect),
		.voltage_full(voltage_full), .rate_select(rate_select), .charge_drive(charge_drive),
		.discharge_drive(discharge_drive), .polling_active(polling_active),
		.soft_start_active(soft_start_active), .fast_charge_active(fast_charge_active),
		.charge_done(charge_done), .hot_fault(hot_fault), .rate_window_open(rate_window_open),
		.rate_active(rate_active));
	cps_battery_model u_cps_battery_model (.charge_drive(charge_drive), .present(present),
		.full(full), .battery_detect(battery_detect), .voltage_full(voltage_full));
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wait_done;
		for (int i = 0; i < 4000 && charge_done !== 1'b1; i++)
			@(posedge sys_clk);
		check("done", charge_done, 1);
	endtask
	task automatic mreset(input int n);
		master_reset_low <= 0;
		repeat (n) @(posedge sys_clk);
		master_reset_low <= 1;
		repeat (3) @(posedge sys_clk);
	endtask
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			n_errors++;
			finish_test();
		end
	end
	always @(posedge sys_clk)
	begin
		dprev <= discharge_drive;
		if (discharge_drive && !dprev && polling_active)
		begin
			if (drise > 0)
				check("cap period", (cyc - drise) % CAPP, 0);
			drise <= cyc;
		end
		if (!polling_active || !master_reset_low)
			drise <= 0;
		run <= charge_drive ? run + 1 : 0;
		if (charge_drive && run == 0 && polling_active && rise > 0)
			check("poll period", cyc - rise, DPER);
		if (charge_drive && run == 0)
			rise <= cyc;
		if (!polling_active || !master_reset_low)
			rise <= 0;
		if (!charge_drive && run > 0 && master_reset_low)
		begin
			if (soft_start_active)
				check("soft pulse", run, nsoft == 0 ? DET + SI : SI + SINC * nsoft);
			if (fast_charge_active)
				check("fast pulse", run, CHARGE_DRIVE);
			if (polling_active)
				check("poll pulse", run, DET);
			nsoft <= nsoft + soft_start_active;
			nfast <= nfast + fast_charge_active;
		end
		if (polling_active)
		begin
			nsoft <= 0;
			nfast <= 0;
		end
	end
	initial
	begin
		sys_rst <= 1'b1;
		master_reset_low <= 1'b1;
		temperature_input <= 1'b0;
		present <= 1'b0;
		full <= 1'b0;
		rate_select <= 2'h0;
		void'($urandom(40));
		repeat (2) @(posedge sys_clk);
		sys_rst <= 0;
		r = 2'($urandom % 4);
		repeat (100) @(posedge sys_clk);
		rate_select <= r;
		repeat (40) @(posedge sys_clk);
		rate_select <= ~r;
		repeat (150) @(posedge sys_clk);
		check("rate", rate_active, r);
		check("window", rate_window_open, 0);
		$display("test polling ended");
		present <= 1;
		wait_done();
		check("fast cycles", nfast, FAST << r);
		$display("test timer ended");
		mreset(RST + 2);
		check("restart", {polling_active, charge_done}, 2'h2);
		full <= 1;
		wait_done();
		check("full stop", nfast, 1);
		$display("test full ended");
		mreset(RST + 2);
		full <= 0;
		repeat ($urandom % 40) @(posedge sys_clk);
		temperature_input <= 1;
		@(posedge sys_clk);
		temperature_input <= 0;
		repeat (30) @(posedge sys_clk);
		check("fault", {hot_fault, charge_drive, discharge_drive}, 3'h4);
		mreset(RST - 1);
		check("short reset", hot_fault, 1);
		mreset(RST + 1);
		check("long reset", hot_fault, 0);
		$display("test fault ended");
		finish_test();
	end
endmodule // cps_sequencer_tb_top
`default_nettype wire
